// >>> rtl/sat_timer.sv
// Purpose: Auto-reload timer, one 16-bit counter or two 8-bit counters
// Assumes: Register port with one-cycle read data, 50 MHz clock
// Notes:   Interrupt output is a level, high while an enabled flag is set, plus a one-cycle pulse for capture
//
// Chosen here: the strobed register port and the address map.

// Notes on behaviour
// - With split mode set the timer is two independent 8-bit counters, each reloading itself.
// - With split mode clear the two bytes form one 16-bit auto-reload counter.
// - Run control gates counting, and in split mode only the high byte, the low byte always running.
// - The alternate clock select picks system /12, external /8, reserved, or oscillator /8.
// - External and oscillator sources are synchronised to the system clock and give no ticks in suspend.
// - One alternate select serves both bytes, each byte choosing it or the full system clock.
// - The high flag is set on high byte rollover from FF, and hardware never clears it.
// - The low flag is set on every low byte overflow in both modes, cleared only by software.
// - With interrupts enabled high overflow interrupts, and with low enable either overflow does.
// - With capture and interrupts enabled an oscillator falling edge copies the count into reload and interrupts.
module sat_timer
	import sat_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic [2:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	input  wire logic       i_suspend,
	input  wire logic       i_ext_clk,
	input  wire logic       i_osc,
	output logic      [7:0] o_rdata,
	output logic            o_irq
);
	typedef struct packed {
		logic       susp_m;
		logic       susp;
		logic [7:0] ctl;
		logic [7:0] cnt_lo;
		logic [7:0] cnt_hi;
		logic [7:0] rl_lo;
		logic [7:0] rl_hi;
		logic [1:0] ckctl;
		logic       ien;
		logic       capt;
		logic [7:0] rdata;
		logic       irq;
	} sat_state_t;

	sat_state_t st_reg;
	sat_state_t st_next;
	sat_bus_t   bus;
	logic [1:0] rst_sync_reg;
	logic       rst_n;
	logic       alt_tick;
	logic       osc_fall;
	logic       tick_lo;
	logic       tick_hi;
	logic       split;
	logic       run;
	logic       inc_lo;
	logic       inc_hi;
	logic       ovf_lo;
	logic       ovf_hi;
	logic [7:0] ctl_w;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	sat_clk_src u_src (
		.i_clk      (i_clk),
		.i_rst_n    (rst_n),
		.i_sel      (st_reg.ctl[1:0]),
		.i_suspend  (st_reg.susp),
		.i_ext_clk  (i_ext_clk),
		.i_osc      (i_osc),
		.o_tick     (alt_tick),
		.o_osc_fall (osc_fall)
	);

	always_comb begin
		st_next          = st_reg;
		st_next.susp_m   = i_suspend;
		st_next.susp     = st_reg.susp_m;
		split            = st_reg.ctl[BIT_SPLIT];
		run              = st_reg.ctl[BIT_RUN];
		// Per byte: alternate tick or every system clock
		tick_lo = st_reg.ckctl[BIT_CKLO] ? 1'b1 : alt_tick;
		tick_hi = st_reg.ckctl[BIT_CKHI] ? 1'b1 : alt_tick;
		if (split) begin
			inc_lo = tick_lo;
			inc_hi = run && tick_hi;
		end else begin
			inc_lo = run && tick_lo;
			inc_hi = inc_lo && (st_reg.cnt_lo == BYTE_MAX);
		end
		ovf_lo = inc_lo && (st_reg.cnt_lo == BYTE_MAX);
		ovf_hi = inc_hi && (st_reg.cnt_hi == BYTE_MAX);

		if (inc_lo)
			st_next.cnt_lo = st_reg.cnt_lo + 8'h01;
		if (inc_hi)
			st_next.cnt_hi = st_reg.cnt_hi + 8'h01;
		if (split) begin
			if (ovf_lo)
				st_next.cnt_lo = st_reg.rl_lo;
			if (ovf_hi)
				st_next.cnt_hi = st_reg.rl_hi;
		end else if (ovf_hi) begin
			st_next.cnt_lo = st_reg.rl_lo;
			st_next.cnt_hi = st_reg.rl_hi;
		end

		st_next.capt = 1'b0;
		ctl_w        = bus.wdata;
		// Software writes
		if (bus.wr) begin
			unique case (bus.addr)
				ADDR_CONTROL:   st_next.ctl   = ctl_w;
				ADDR_COUNT_LO:  st_next.cnt_lo = bus.wdata;
				ADDR_COUNT_HI:  st_next.cnt_hi = bus.wdata;
				ADDR_RELOAD_LO: st_next.rl_lo = bus.wdata;
				ADDR_RELOAD_HI: st_next.rl_hi = bus.wdata;
				ADDR_CLKCTL:    st_next.ckctl = bus.wdata[1:0];
				ADDR_IRQ_EN:    st_next.ien   = bus.wdata[BIT_IEN];
				default:        st_next.ctl   = st_reg.ctl;
			endcase
		end
		// Hardware set wins over a software clear in the same cycle
		if (ovf_hi)
			st_next.ctl[BIT_HOF] = 1'b1;
		if (ovf_lo)
			st_next.ctl[BIT_LOF] = 1'b1;
		if (osc_fall && st_reg.ctl[BIT_CAPEN] && st_reg.ien) begin
			st_next.rl_lo = st_reg.cnt_lo;
			st_next.rl_hi = st_reg.cnt_hi;
			st_next.capt  = 1'b1;
		end

		st_next.rdata = 8'h00;
		if (bus.rd) begin
			unique case (bus.addr)
				ADDR_CONTROL:   st_next.rdata = st_reg.ctl;
				ADDR_COUNT_LO:  st_next.rdata = st_reg.cnt_lo;
				ADDR_COUNT_HI:  st_next.rdata = st_reg.cnt_hi;
				ADDR_RELOAD_LO: st_next.rdata = st_reg.rl_lo;
				ADDR_RELOAD_HI: st_next.rdata = st_reg.rl_hi;
				ADDR_CLKCTL:    st_next.rdata = {6'h00, st_reg.ckctl};
				ADDR_IRQ_EN:    st_next.rdata = {7'h00, st_reg.ien};
				default:        st_next.rdata = 8'h00;
			endcase
		end
		// Level request from flags, plus a one-cycle pulse for capture
		st_next.irq = st_next.ien && (st_next.ctl[BIT_HOF]
			|| (st_next.ctl[BIT_LIEN] && st_next.ctl[BIT_LOF]) || st_next.capt);
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg.susp_m <= 1'b0;
			st_reg.susp   <= 1'b0;
			st_reg.ctl    <= CONTROL_RESET;
			st_reg.cnt_lo <= BYTE_RESET;
			st_reg.cnt_hi <= BYTE_RESET;
			st_reg.rl_lo  <= BYTE_RESET;
			st_reg.rl_hi  <= BYTE_RESET;
			st_reg.ckctl  <= 2'h0;
			st_reg.ien    <= 1'b0;
			st_reg.capt   <= 1'b0;
			st_reg.rdata  <= 8'h00;
			st_reg.irq    <= 1'b0;
		end else begin
			st_reg.susp_m <= st_next.susp_m;
			st_reg.susp   <= st_next.susp;
			st_reg.ctl    <= st_next.ctl;
			st_reg.cnt_lo <= st_next.cnt_lo;
			st_reg.cnt_hi <= st_next.cnt_hi;
			st_reg.rl_lo  <= st_next.rl_lo;
			st_reg.rl_hi  <= st_next.rl_hi;
			st_reg.ckctl  <= st_next.ckctl;
			st_reg.ien    <= st_next.ien;
			st_reg.capt   <= st_next.capt;
			st_reg.rdata  <= st_next.rdata;
			st_reg.irq    <= st_next.irq;
		end
	end

	assign o_rdata = st_reg.rdata;
	assign o_irq   = st_reg.irq;

	chk_high_flag_set: assert property (@(posedge i_clk) disable iff (!rst_n)
		ovf_hi |=> st_reg.ctl[BIT_HOF]) else $error("high flag not set");
	chk_high_flag_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
		st_reg.ctl[BIT_HOF] && !bus.wr |=> st_reg.ctl[BIT_HOF]) else $error("high flag lost");
	chk_low_flag_set: assert property (@(posedge i_clk) disable iff (!rst_n)
		ovf_lo |=> st_reg.ctl[BIT_LOF]) else $error("low flag not set");
	chk_low_flag_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
		st_reg.ctl[BIT_LOF] && !bus.wr |=> st_reg.ctl[BIT_LOF]) else $error("low flag lost");
	chk_split_reload: assert property (@(posedge i_clk) disable iff (!rst_n)
		split && ovf_lo && !bus.wr |=> st_reg.cnt_lo == $past(st_reg.rl_lo)) else $error("no reload");
	chk_wide_carry: assert property (@(posedge i_clk) disable iff (!rst_n)
		!split && inc_lo && st_reg.cnt_lo == BYTE_MAX && st_reg.cnt_hi != BYTE_MAX && !bus.wr
		|=> st_reg.cnt_hi == $past(st_reg.cnt_hi) + 8'h01) else $error("no carry");
	chk_lo_free_run: assert property (@(posedge i_clk) disable iff (!rst_n)
		split && !run && tick_lo && st_reg.cnt_lo != BYTE_MAX && !bus.wr
		|=> st_reg.cnt_lo == $past(st_reg.cnt_lo) + 8'h01) else $error("low byte stalled");
	chk_hi_gated: assert property (@(posedge i_clk) disable iff (!rst_n)
		!run && !bus.wr |=> st_reg.cnt_hi == $past(st_reg.cnt_hi)) else $error("high byte ran");
	chk_irq_level: assert property (@(posedge i_clk) disable iff (!rst_n)
		st_reg.ien && st_reg.ctl[BIT_HOF] |-> o_irq) else $error("irq missing");
	chk_irq_off: assert property (@(posedge i_clk) disable iff (!rst_n)
		!st_reg.ien |-> !o_irq) else $error("irq while disabled");
	chk_capture: assert property (@(posedge i_clk) disable iff (!rst_n)
		osc_fall && st_reg.ctl[BIT_CAPEN] && st_reg.ien |=> st_reg.capt && o_irq) else $error("no capture");
	chk_fast_clock: assert property (@(posedge i_clk) disable iff (!rst_n)
		split && st_reg.ckctl[BIT_CKLO] && st_reg.cnt_lo != BYTE_MAX && !bus.wr
		|=> st_reg.cnt_lo == $past(st_reg.cnt_lo) + 8'h01) else $error("fast clock idle");

	cov_split_ovf: cover property (@(posedge i_clk) disable iff (!rst_n) split && ovf_hi && ovf_lo);
	cov_wide_ovf:  cover property (@(posedge i_clk) disable iff (!rst_n) !split && ovf_hi);
	cov_capture:   cover property (@(posedge i_clk) disable iff (!rst_n) st_reg.capt);
	cov_alt_tick:  cover property (@(posedge i_clk) disable iff (!rst_n) alt_tick && !st_reg.ckctl[BIT_CKLO]);
endmodule : sat_timer

// >>> rtl/sat_pkg.sv
// Purpose: Shared constants and types for the split auto-reload timer
// Assumes: Single 50 MHz system clock, register port with one-cycle read latency
// Notes:   Offsets index a small private register space
package sat_pkg;
	localparam logic [2:0] ADDR_CONTROL   = 3'h0;
	localparam logic [2:0] ADDR_COUNT_LO  = 3'h1;
	localparam logic [2:0] ADDR_COUNT_HI  = 3'h2;
	localparam logic [2:0] ADDR_RELOAD_LO = 3'h3;
	localparam logic [2:0] ADDR_RELOAD_HI = 3'h4;
	localparam logic [2:0] ADDR_CLKCTL    = 3'h5;
	localparam logic [2:0] ADDR_IRQ_EN    = 3'h6;

	localparam int BIT_HOF   = 7;
	localparam int BIT_LOF   = 6;
	localparam int BIT_LIEN  = 5;
	localparam int BIT_CAPEN = 4;
	localparam int BIT_SPLIT = 3;
	localparam int BIT_RUN   = 2;
	localparam int BIT_CKHI  = 1;
	localparam int BIT_CKLO  = 0;
	localparam int BIT_IEN   = 0;

	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET    = 8'h00;
	localparam logic [7:0] BYTE_MAX      = 8'hFF;

	localparam logic [1:0] ALT_DIV12 = 2'h0;
	localparam logic [1:0] ALT_EXT8  = 2'h1;
	localparam logic [1:0] ALT_OSC8  = 2'h3;

	localparam logic [3:0] DIV12_LAST = 4'hB;
	localparam logic [2:0] DIV8_LAST  = 3'h7;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sat_bus_t;

	typedef struct packed {
		logic [2:0] s_ext;
		logic [2:0] s_osc;
		logic [2:0] d_ext;
		logic [2:0] d_osc;
		logic [3:0] d12;
		logic       tick;
	} sat_src_t;
endpackage : sat_pkg

// >>> rtl/sat_clk_src.sv
// Purpose: Alternate timer tick source: system clock /12, external /8, oscillator /8
// Assumes: External and oscillator inputs are asynchronous to i_clk
// Notes:   Emits a one-cycle tick enable, never a derived clock
module sat_clk_src
	import sat_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic [1:0] i_sel,
	input  wire logic       i_suspend,
	input  wire logic       i_ext_clk,
	input  wire logic       i_osc,
	output logic            o_tick,
	output logic            o_osc_fall
);
	sat_src_t st_reg;
	sat_src_t st_next;
	logic     ext_rise;
	logic     osc_rise;

	always_comb begin
		st_next       = st_reg;
		st_next.s_ext = {st_reg.s_ext[1:0], i_ext_clk};
		st_next.s_osc = {st_reg.s_osc[1:0], i_osc};
		// Edges are taken from the second and third stages only
		ext_rise      = st_reg.s_ext[1] & ~st_reg.s_ext[2];
		osc_rise      = st_reg.s_osc[1] & ~st_reg.s_osc[2];
		st_next.tick  = 1'b0;
		st_next.d12   = (st_reg.d12 == DIV12_LAST) ? 4'h0 : st_reg.d12 + 4'h1;
		if (ext_rise)
			st_next.d_ext = st_reg.d_ext + 3'h1;
		if (osc_rise)
			st_next.d_osc = st_reg.d_osc + 3'h1;
		unique case (i_sel)
			ALT_DIV12: st_next.tick = (st_reg.d12 == DIV12_LAST);
			ALT_EXT8:  st_next.tick = ext_rise && (st_reg.d_ext == DIV8_LAST);
			ALT_OSC8:  st_next.tick = osc_rise && (st_reg.d_osc == DIV8_LAST);
			default:   st_next.tick = 1'b0;
		endcase
		// No alternate ticks while suspended
		if (i_suspend)
			st_next.tick = 1'b0;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign o_tick     = st_reg.tick;
	assign o_osc_fall = st_reg.s_osc[2] & ~st_reg.s_osc[1];

	chk_tick_suspend: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_suspend |=> !o_tick) else $error("tick during suspend");
endmodule : sat_clk_src

// >>> sim/sat_timer_tb.sv
// Purpose: Self-checking bench for the split auto-reload timer
// Assumes: Registers reached over the one-cycle strobe port, 50 MHz clock
// Notes:   Expected values are fixed constants, except the random count for capture, with ranges where tick phase varies
module sat_timer_tb
	import sat_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk;
	logic       rst_n;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic       susp;
	logic       ext;
	logic       osc;
	logic       osc_on;
	logic [7:0] rdata;
	logic       irq;
	logic [7:0] d;
	logic [7:0] v;
	logic       seen;
	int         failures = 0;
	int         checks   = 0;
	int         cycles   = 0;
	int         i;

	sat_timer i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.i_suspend(susp), .i_ext_clk(ext), .i_osc(osc), .o_rdata(rdata), .o_irq(irq));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Free-running external pin, and an oscillator pin that toggles only while osc_on is set, asynchronous in spirit
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles % 2 == 0) ext <= ~ext;
		if (osc_on && cycles % 4 == 0) osc <= ~osc;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] dv);
		@(posedge clk);
		addr  <= a;
		wdata <= dv;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [2:0] a, output logic [7:0] q);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 q = rdata;
	endtask

	task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic cmp_rng(input string what, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] g);
		checks++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			failures++;
			$display("unexpected %s expected %h..%h seen %h", what, lo, hi, g);
		end
	endtask

	// Low byte in split mode runs without the run bit, so it measures the tick rate
	task automatic rate(input logic [1:0] sel, input int n, input logic [7:0] lo, input logic [7:0] hi);
		wr_reg(ADDR_CONTROL, 8'h08 | {6'h00, sel});
		wr_reg(ADDR_COUNT_LO, 8'h00);
		repeat (n) @(posedge clk);
		rd_reg(ADDR_COUNT_LO, d);
		cmp_rng("tick count", lo, hi, d);
	endtask

	task automatic irq_is(input logic e);
		repeat (3) @(posedge clk);
		#1 cmp("irq", {7'h00, e}, {7'h00, irq});
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		{rst_n, addr, wdata, wr, rd, susp, ext, osc} = '0;
		osc_on = 1'b1;
		i = $urandom(17);
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		wr_reg(3'h7, 8'hA5);
		for (i = 0; i < 8; i++) begin
			rd_reg(i[2:0], d);
			cmp("reset value", 8'h00, d);
		end
		$display("test reset done");
		rate(ALT_DIV12, 120, 8'h09, 8'h0B);
		rate(ALT_EXT8, 160, 8'h04, 8'h06);
		rate(ALT_OSC8, 320, 8'h04, 8'h06);
		rate(2'h2, 160, 8'h00, 8'h00);
		susp <= 1'b1;
		repeat (6) @(posedge clk);
		rate(ALT_EXT8, 160, 8'h00, 8'h01);
		susp <= 1'b0;
		$display("test clock select done");
		wr_reg(ADDR_CLKCTL, 8'h03);
		wr_reg(ADDR_RELOAD_LO, 8'hF0);
		wr_reg(ADDR_RELOAD_HI, 8'hA0);
		wr_reg(ADDR_COUNT_HI, 8'h55);
		wr_reg(ADDR_COUNT_LO, 8'hE0);
		wr_reg(ADDR_CONTROL, 8'h08);
		repeat (40) @(posedge clk);
		rd_reg(ADDR_COUNT_LO, d);
		cmp_rng("split low", 8'hF0, 8'hFF, d);
		rd_reg(ADDR_COUNT_HI, d);
		cmp("split high idle", 8'h55, d);
		rd_reg(ADDR_CONTROL, d);
		cmp("split flags", 8'h48, d);
		wr_reg(ADDR_COUNT_HI, 8'hFE);
		wr_reg(ADDR_CONTROL, 8'h0C);
		repeat (20) @(posedge clk);
		rd_reg(ADDR_CONTROL, d);
		cmp("run flags", 8'hCC, d);
		rd_reg(ADDR_COUNT_HI, d);
		cmp_rng("split high", 8'hA0, 8'hB8, d);
		wr_reg(ADDR_CONTROL, 8'hC8);
		repeat (50) @(posedge clk);
		rd_reg(ADDR_CONTROL, d);
		cmp("flags kept", 8'hC8, d);
		$display("test split done");
		wr_reg(ADDR_IRQ_EN, 8'h01);
		irq_is(1'b1);
		wr_reg(ADDR_CONTROL, 8'h48);
		irq_is(1'b0);
		wr_reg(ADDR_CONTROL, 8'h68);
		irq_is(1'b1);
		wr_reg(ADDR_IRQ_EN, 8'h00);
		irq_is(1'b0);
		$display("test interrupt done");
		wr_reg(ADDR_CONTROL, 8'h00);
		wr_reg(ADDR_RELOAD_HI, 8'hFF);
		wr_reg(ADDR_COUNT_HI, 8'hFE);
		wr_reg(ADDR_COUNT_LO, 8'hF8);
		wr_reg(ADDR_CONTROL, 8'h04);
		repeat (30) @(posedge clk);
		rd_reg(ADDR_COUNT_HI, d);
		cmp("carry high", 8'hFF, d);
		rd_reg(ADDR_CONTROL, d);
		cmp("carry flags", 8'h44, d);
		repeat (300) @(posedge clk);
		rd_reg(ADDR_CONTROL, d);
		cmp("wide flags", 8'hC4, d);
		rd_reg(ADDR_COUNT_HI, d);
		cmp("wide high", 8'hFF, d);
		rd_reg(ADDR_COUNT_LO, d);
		cmp_rng("wide low", 8'hF0, 8'hFF, d);
		$display("test wide done");
		osc_on <= 1'b0;
		osc    <= 1'b1;
		v = 8'($urandom);
		wr_reg(ADDR_CONTROL, 8'h00);
		wr_reg(ADDR_COUNT_HI, v);
		wr_reg(ADDR_COUNT_LO, ~v);
		wr_reg(ADDR_IRQ_EN, 8'h01);
		wr_reg(ADDR_CONTROL, 8'h10);
		repeat (4) @(posedge clk);
		#1 cmp("irq before capture", 8'h00, {7'h00, irq});
		osc  <= 1'b0;
		seen = 1'b0;
		for (i = 0; i < 10; i++) begin
			@(posedge clk);
			#1 seen = seen | (irq === 1'b1);
		end
		cmp("capture irq", 8'h01, {7'h00, seen});
		rd_reg(ADDR_RELOAD_HI, d);
		cmp("capture high", v, d);
		rd_reg(ADDR_RELOAD_LO, d);
		cmp("capture low", ~v, d);
		$display("test capture done");
		give_verdict();
	end
endmodule // sat_timer_tb
